// file: rtl/tt_frame_uframe_sync.sv
// microframe and frame timer lock and translator gating
// Contract
// - two consecutive microframe SOFs lock microframe timer
// - zeroth microframe means frame number plus one
// - frame start at SOF with changed number
// - frame lock needs zeroth SOF after microframe lock
// - frame stays locked counting eight microframes
// - three missed SOFs drop both locks
// - full-speed SOFs only with frame lock
// - SOFs resume at start of next frame
// - microframe number and zeroth microframe drive pipeline
// - buffered periodic complete-splits still answered
// - loss of lock flushes periodic start-splits
// - periodic start-splits ignored while unlocked
// - no SOFs or keep-alives while unlocked
// - no new periodic downstream work while unlocked
// - bulk/control splits still accepted and answered
// - bulk/control held, not issued, until relock or clear
// - nothing downstream while upstream port suspended
// - normal operation needs both timers locked
// - protocol one single, two multiple translators
`timescale 1ns/10ps
module tt_frame_uframe_sync
   import tt_sync_pkg::*;
#(
   parameter int unsigned UFRAME_CYCLES = UFRAME_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   input  wire tt_sync_pkg::sof_t    sof,
   input  wire tt_sync_pkg::split_t  split,
   input  wire logic                 clear_tt_buf,
   input  wire logic                 suspend_pin,
   input  wire logic [1:0]           if_protocol,
   input  wire logic                 fl_busy,
   output tt_sync_pkg::gate_t        gate,
   output logic                      uframe_locked,
   output logic                      frame_locked,
   output logic [2:0]                uframe_num,
   output logic                      multi_tt,
   output logic                      split_ignored
);
   import tt_sync_pkg::*;

   localparam int CW = $clog2(UFRAME_CYCLES + 1);
   localparam logic [CW-1:0] TICK_LAST = CW'(UFRAME_CYCLES - 1);
   localparam logic [1:0] MISS_LAST = 2'(MISS_LIMIT - 1);
   localparam logic [1:0] LOCK_LAST = 2'(LOCK_SOFS - 1);

   ////////////////////////////////////////////////////////////////////////
   // suspend pin synchroniser
   // only the second flop is read; the first may be metastable
   logic susp_r;

   bit_sync #(
      .RST_VAL (1'b0)
   ) sync_u (
      .mclk   (mclk),
      .arst_n (arst_n),
      .d      (suspend_pin),
      .q      (susp_r)
   );

   ////////////////////////////////////////////////////////////////////////
   // microframe window: restarted by every SOF so an early SOF never reads as miss
   logic [CW-1:0] tick_r, tick_nxt;
   // one-cycle marker after each microframe boundary
   logic          tick_r1, tick_nxt1;
   logic          tick_end;
   logic          miss_win;

   assign tick_end = (tick_r == TICK_LAST);
   // a window that closes with no SOF in it is a missed microframe
   assign miss_win = tick_end && !sof.valid;

   always_comb begin
      tick_nxt  = tick_end ? '0 : tick_r + CW'(1);
      tick_nxt1 = sof.valid || miss_win;
      if (sof.valid) begin
         tick_nxt = '0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tick_r  <= '0;
         tick_r1 <= 1'b0;
      end else begin
         tick_r  <= tick_nxt;
         tick_r1 <= tick_nxt1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // microframe lock: consecutive SOF count and missed window count
   logic [1:0]         miss_r, miss_nxt;
   logic [1:0]         hits_r, hits_nxt;
   logic               prev_ok_r, prev_ok_nxt;
   logic [FRNUM_W-1:0] prev_fn_r, prev_fn_nxt;
   logic               ulock_r, ulock_nxt;
   logic               flush_r, flush_nxt;
   logic               lose_lock;
   logic               zero_sof;

   assign lose_lock = miss_win && (miss_r == MISS_LAST);
   // frame number moved on by one since the last microframe: zeroth SOF
   assign zero_sof  = sof.valid && prev_ok_r &&
                      (sof.frnum == prev_fn_r + FRNUM_W'(1));

   always_comb begin
      miss_nxt    = miss_r;
      hits_nxt    = hits_r;
      prev_ok_nxt = prev_ok_r;
      prev_fn_nxt = prev_fn_r;
      ulock_nxt   = ulock_r;
      flush_nxt   = 1'b0;
      if (sof.valid) begin
         miss_nxt    = '0;
         prev_ok_nxt = 1'b1;
         prev_fn_nxt = sof.frnum;
         if (hits_r != LOCK_LAST) begin
            hits_nxt = hits_r + 2'h1;
         end
         if (ulock_r || hits_r == LOCK_LAST) begin
            ulock_nxt = 1'b1;
         end
      end else if (miss_win) begin
         prev_ok_nxt = 1'b0;
         hits_nxt    = '0;
         // a lost lock flushes only when it was held, not on idle misses
         if (lose_lock) begin
            miss_nxt  = '0;
            ulock_nxt = 1'b0;
            flush_nxt = ulock_r;
         end else begin
            miss_nxt = miss_r + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         miss_r    <= '0;
         hits_r    <= '0;
         prev_ok_r <= 1'b0;
         prev_fn_r <= '0;
         ulock_r   <= 1'b0;
         flush_r   <= 1'b0;
      end else begin
         miss_r    <= miss_nxt;
         hits_r    <= hits_nxt;
         prev_ok_r <= prev_ok_nxt;
         prev_fn_r <= prev_fn_nxt;
         ulock_r   <= ulock_nxt;
         flush_r   <= flush_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // microframe number: steps once per microframe, seen or missed
   logic [2:0] ufn_r, ufn_nxt;
   logic       uframe_step;
   logic       frame_wrap;

   assign uframe_step = sof.valid || miss_win;
   // eight microframes on from the zeroth one a new frame begins
   assign frame_wrap  = uframe_step && (ufn_r == UFRAME_LAST);

   always_comb begin
      ufn_nxt = ufn_r;
      if (uframe_step) begin
         ufn_nxt = ufn_r + 3'h1;
      end
      // a zeroth SOF pulls the count back in line
      if (zero_sof) begin
         ufn_nxt = UFRAME_ZERO;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ufn_r <= '0;
      end else begin
         ufn_r <= ufn_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame lock and downstream SOF arming
   logic flock_r, flock_nxt;
   logic sof_go_r, sof_go_nxt;

   always_comb begin
      flock_nxt  = flock_r;
      sof_go_nxt = sof_go_r;
      // a zeroth SOF only counts once microframes are locked
      if (zero_sof && ulock_r) begin
         flock_nxt = 1'b1;
      end
      // SOFs wait for a whole frame after lock, never a partial one
      if (flock_r && frame_wrap) begin
         sof_go_nxt = 1'b1;
      end
      if (lose_lock) begin
         flock_nxt  = 1'b0;
         sof_go_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flock_r  <= 1'b0;
         sof_go_r <= 1'b0;
      end else begin
         flock_r  <= flock_nxt;
         sof_go_r <= sof_go_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // translator organization latch
   // the protocol is only taken while no full-/low-speed work is in flight
   logic [1:0] proto_r, proto_nxt;

   always_comb begin
      proto_nxt = proto_r;
      if (!fl_busy) begin
         proto_nxt = if_protocol;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         proto_r <= PROTO_SINGLE;
      end else begin
         proto_r <= proto_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // gating of translator activity
   logic up;
   logic run;
   logic ds_run;
   logic fs_run;

   // a suspended upstream port silences everything downstream
   assign up     = !susp_r;
   assign run    = ulock_r && flock_r;
   assign ds_run = run && up;
   assign fs_run = ds_run && sof_go_r;

   always_comb begin
      // downstream frame markers
      gate.fs_sof             = fs_run;
      gate.ls_keepalive       = fs_run;
      // periodic pipeline
      gate.periodic_start_ok  = ds_run;
      gate.periodic_ss_accept = ulock_r;
      gate.periodic_flush     = flush_r;
      gate.periodic_cs_answer = 1'b1;
      // bulk/control buffers
      gate.bulk_issue_ok      = ds_run;
      gate.bulk_ss_accept     = 1'b1;
      gate.bulk_cs_answer     = 1'b1;
      gate.bulk_keep          = !ulock_r && !clear_tt_buf;
      // microframe pacing for the pipeline
      gate.uframe_tick        = tick_r1 && ulock_r;
   end

   // status seen by the rest of the hub
   assign uframe_locked = ulock_r;
   assign frame_locked  = flock_r;
   assign uframe_num    = ufn_r;
   assign multi_tt      = (proto_r == PROTO_MULTI);
   assign split_ignored = split.valid && split.periodic && split.start &&
                          !ulock_r;
endmodule : tt_frame_uframe_sync

////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for a pin from outside the clock domain
module bit_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : bit_sync

// file: rtl/tt_sync_pkg.sv
// shared constants and types for the translator frame/microframe sync block
package tt_sync_pkg;
   // microframe period in ns and its length in mclk cycles at 10 MHz
   localparam int unsigned UFRAME_NS      = 125000;
   localparam int unsigned CLK_NS         = 100;
   localparam int unsigned UFRAME_CYC     = UFRAME_NS / CLK_NS;
   localparam int unsigned UFRAMES_PER_FR = 8;
   localparam int unsigned MISS_LIMIT     = 3;
   localparam int unsigned LOCK_SOFS      = 2;
   localparam int unsigned FRNUM_W        = 11;
   localparam logic [2:0]  UFRAME_ZERO    = 3'h0;
   localparam logic [2:0]  UFRAME_LAST    = 3'h7;
   localparam logic [1:0]  PROTO_SINGLE   = 2'h1;
   localparam logic [1:0]  PROTO_MULTI    = 2'h2;

   // start-of-frame packet seen upstream
   typedef struct packed {
      logic               valid;
      logic [FRNUM_W-1:0] frnum;
   } sof_t;

   // one split transaction token seen upstream
   typedef struct packed {
      logic valid;
      logic periodic;
      logic start;
   } split_t;

   // gates handed to the rest of the translator
   typedef struct packed {
      logic fs_sof;
      logic ls_keepalive;
      logic periodic_start_ok;
      logic periodic_ss_accept;
      logic periodic_flush;
      logic periodic_cs_answer;
      logic bulk_issue_ok;
      logic bulk_ss_accept;
      logic bulk_cs_answer;
      logic bulk_keep;
      logic uframe_tick;
   } gate_t;
endpackage : tt_sync_pkg

// file: verif/sof_host_model.sv
// host model issuing one sof per microframe
`timescale 1ns/10ps
module sof_host_model
   import tt_sync_pkg::*;
#(parameter int unsigned PER = 20) (
   input  wire logic         mclk,
   input  wire logic         en,
   input  wire logic [10:0]  fn0,
   input  wire logic [2:0]   uf0,
   output tt_sync_pkg::sof_t sof
);
   int unsigned cnt = 0;
   logic [13:0] pos = '0;
   initial sof = '0;
   always @(posedge mclk) begin
      #1;
      sof.valid = 1'b0;
      sof.frnum = ~sof.frnum;
      if (!en) begin
         cnt = 0;
         pos = {fn0, uf0};
      end else begin
         if (cnt == 0) begin
            sof.valid = 1'b1;
            sof.frnum = pos[13:3];
            pos = pos + 14'h1;
         end
         cnt = (cnt + 1) % PER;
      end
   end
endmodule : sof_host_model

// file: verif/tt_frame_uframe_sync_tb_top.sv
// self-checking bench for the translator sync block
`timescale 1ns/10ps
module tt_frame_uframe_sync_tb_top;
   import tt_sync_pkg::*;
   localparam int unsigned PER = 20;
   logic        mclk, arst_n, en, clear_tt_buf, suspend_pin, fl_busy;
   logic        ufl, frl, multi_tt, split_ignored, seen;
   logic [10:0] fn0 = 11'h7ff;
   logic [2:0]  uf0 = 3'h6, uframe_num;
   logic [1:0]  if_protocol;
   sof_t        sof;
   split_t      split;
   gate_t       gate;
   int          miscompares = 0, n_compared = 0, cycles = 0;
   tt_frame_uframe_sync #(.UFRAME_CYCLES(PER)) dut_u (.mclk, .arst_n,
      .sof, .split, .clear_tt_buf, .suspend_pin, .if_protocol, .fl_busy,
      .gate, .uframe_locked(ufl), .frame_locked(frl), .uframe_num,
      .multi_tt, .split_ignored);
   sof_host_model #(.PER(PER)) host_u (.mclk, .en, .fn0, .uf0, .sof);
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic chk(string nm, logic [2:0] exp, logic [2:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wsof(int n);
      repeat (n) @(posedge sof.valid);
      cyc(1);
   endtask : wsof
   task automatic t_split(logic lk);
      split = 3'h7;
      #1;
      chk("split_ignored", !lk, split_ignored);
      chk("ss_accept", lk, gate.periodic_ss_accept);
      chk("bulk_ss", 1, gate.bulk_ss_accept);
      chk("bulk_keep", !lk, gate.bulk_keep);
      cyc(1);
      split = '0;
   endtask : t_split
   task automatic t_lock();
      chk("frame_locked", 0, frl);
      chk("fs_sof", 0, gate.fs_sof);
      en = 1;
      wsof(2);
      chk("uframe_locked", 1, ufl);
      chk("frame_locked", 0, frl);
      wsof(1);
      chk("frame_locked", 1, frl);
      chk("uframe_num", 0, uframe_num);
      chk("uframe_tick", 1, gate.uframe_tick);
      chk("fs_sof", 0, gate.fs_sof);
      wsof(8);
      chk("fs_sof", 1, gate.fs_sof);
      chk("uframe_num", 0, uframe_num);
      chk("start_ok", 1, gate.periodic_start_ok);
      t_split(1);
   endtask : t_lock
   task automatic t_other();
      suspend_pin = 1;
      cyc(4);
      chk("bulk_issue", 0, gate.bulk_issue_ok);
      suspend_pin = 0;
      if_protocol = 2'h2;
      cyc(4);
      chk("bulk_issue", 1, gate.bulk_issue_ok);
      chk("multi_tt", 1, multi_tt);
      fl_busy = 1;
      if_protocol = 2'h1;
      cyc(3);
      chk("multi_tt", 1, multi_tt);
      fl_busy = 0;
      cyc(3);
      chk("multi_tt", 0, multi_tt);
   endtask : t_other
   task automatic t_loss();
      wsof(1);
      en = 0;
      cyc(PER * 2);
      chk("frame_locked", 1, frl);
      seen = 0;
      repeat (PER * 2) begin
         cyc(1);
         seen |= gate.periodic_flush;
      end
      chk("uframe_locked", 0, ufl);
      chk("frame_locked", 0, frl);
      chk("flush", 1, seen);
      chk("uframe_tick", 0, gate.uframe_tick);
      chk("start_ok", 0, gate.periodic_start_ok);
      t_split(0);
      clear_tt_buf = 1;
      #1;
      chk("bulk_keep", 0, gate.bulk_keep);
   endtask : t_loss
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   initial begin
      {en, clear_tt_buf, suspend_pin, fl_busy, arst_n} = '0;
      if_protocol = 2'h1;
      split = '0;
      repeat (4) @(posedge mclk);
      #1 arst_n = 1;
      t_lock();
      t_other();
      t_loss();
      print_verdict();
   end
endmodule : tt_frame_uframe_sync_tb_top

// file: verif/tt_sync_props.sv
// port-level assertions for the translator sync block
`timescale 1ns/10ps
module tt_sync_props
   import tt_sync_pkg::*;
(
   input wire logic               mclk,
   input wire logic               arst_n,
   input wire tt_sync_pkg::sof_t   sof,
   input wire tt_sync_pkg::split_t split,
   input wire logic               clear_tt_buf,
   input wire logic               suspend_pin,
   input wire tt_sync_pkg::gate_t  gate,
   input wire logic               uframe_locked,
   input wire logic               frame_locked,
   input wire logic [2:0]         uframe_num,
   input wire logic               split_ignored
);
   import tt_sync_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_frame_needs_uf: assert property (frame_locked |-> uframe_locked)
      else $error("frame lock without microframe lock");
   a_sof_gated: assert property (gate.fs_sof |-> frame_locked)
      else $error("downstream sof without frame lock");
   a_keepalive_tied: assert property (gate.ls_keepalive == gate.fs_sof)
      else $error("keep-alive differs from sof enable");
   a_issue_gated: assert property ((gate.periodic_start_ok ||
      gate.bulk_issue_ok) |-> frame_locked && uframe_locked)
      else $error("downstream issue while unlocked");
   a_uf_lock_cause: assert property ($rose(uframe_locked) |->
      $past(sof.valid))
      else $error("microframe lock without sof");
   a_fr_lock_zero: assert property ($rose(frame_locked) |->
      $past(uframe_locked) && uframe_num == 3'h0)
      else $error("frame lock at wrong point");
   a_flush_loss: assert property ($fell(uframe_locked) |->
      ##[0:1] gate.periodic_flush)
      else $error("no flush on lock loss");
   a_ss_accept: assert property (gate.periodic_ss_accept == uframe_locked)
      else $error("periodic start-split accept wrong");
   a_split_ignore: assert property (split_ignored == (split.valid &&
      split.periodic && split.start && !uframe_locked))
      else $error("split ignore flag wrong");
   a_bulk_kept: assert property (gate.bulk_keep ==
      (!uframe_locked && !clear_tt_buf) && gate.bulk_ss_accept &&
      gate.bulk_cs_answer && gate.periodic_cs_answer)
      else $error("bulk or answer gating wrong");
   a_suspend_quiet: assert property (suspend_pin [*4] |->
      !gate.fs_sof && !gate.bulk_issue_ok)
      else $error("downstream activity while suspended");
endmodule : tt_sync_props
bind tt_frame_uframe_sync tt_sync_props props_u (.mclk, .arst_n, .sof,
   .split, .clear_tt_buf, .suspend_pin, .gate, .uframe_locked,
   .frame_locked, .uframe_num, .split_ignored);
